/* src/sysrv_pkg.sv */
package sysrv_pkg;

    // Register byte addresses on the plain register port
    localparam logic [15:0] ADDR_CAUSE = 16'hfe01;
    localparam logic [15:0] ADDR_ISTAT = 16'hfe02;
    localparam logic [15:0] ADDR_IMASK = 16'hfe03;
    localparam logic [15:0] ADDR_PEND_A = 16'hfe04;
    localparam logic [15:0] ADDR_PEND_B = 16'hfe05;
    localparam logic [15:0] ADDR_PEND_C = 16'hfe06;
    localparam logic [15:0] ADDR_WDOG_SVC = 16'hffff;

    // Fixed vector locations
    localparam logic [15:0] VEC_RESET_HI = 16'hfffe;
    localparam logic [15:0] VEC_RESET_LO = 16'hffff;
    // High byte of flag n sits at VEC_IRQ_BASE - 2n (flag 1 at fffa, flag 14 at ffe0)
    localparam logic [15:0] VEC_IRQ_BASE = 16'hfffc;
    localparam logic [15:0] VEC_KBD_HI = 16'hffe0;
    localparam logic [15:0] VEC_KBD_LO = 16'hffe1;

    // Reset cause bit positions, shared by cause, status and mask registers
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_PIN = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_BADOP = 4;
    localparam int CAUSE_BADADR = 3;
    localparam int CAUSE_UV = 1;
    localparam logic [7:0] CAUSE_RESET = 8'h80;
    localparam logic [7:0] ISTAT_RESET = 8'h00;
    localparam logic [7:0] IMASK_RESET = 8'h00;
    localparam logic [7:0] PEND_RESET = 8'h00;

    // Core presets
    localparam logic [15:0] SP_RESET = 16'h00ff;

    // Reset pin low time in clk cycles
    localparam int RST_HOLD_CYCLES = 32;
    localparam int RST_CNT_W = 6;

    // System prescale counter and the stages a service clears
    localparam int PRESCALE_BITS = 12;
    localparam int SVC_CLR_LO = 4;
    localparam int SVC_CLR_HI = 11;

    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_RUN,
        ST_HOLD,
        ST_WAIT_PIN,
        ST_VEC_HI,
        ST_VEC_LO,
        ST_LOAD
    } sysrv_state_t;

endpackage

/* src/sysrv_sync.sv */
`timescale 1ns/100ps
module sysrv_sync
    import sysrv_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic [WIDTH-1:0] din, // Asynchronous levels
    output logic [WIDTH-1:0] dout // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two stages; the first is read by the second only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

/* src/sysrv_wdog.sv */
`timescale 1ns/100ps
module sysrv_wdog
    import sysrv_pkg::*;
#(
    parameter int WD_BITS = 8
) (
    input wire logic clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic hold, // Keep both counters cleared
    input wire logic osc_tick, // One pulse per oscillator rising edge
    input wire logic service, // Watchdog service write
    output logic timeout // Pulse on watchdog overflow
);

    localparam logic [PRESCALE_BITS-1:0] KEEP_MASK =
        PRESCALE_BITS'((1 << SVC_CLR_LO) - 1);
    localparam logic [PRESCALE_BITS-1:0] PRE_ONE = PRESCALE_BITS'(1);
    localparam logic [WD_BITS-1:0] WD_ONE = WD_BITS'(1);

    generate
        if (WD_BITS < 1 || WD_BITS > 16) begin : g_bad_width
            $error("sysrv_wdog: WD_BITS must lie in 1..16");
        end
    endgenerate

    logic [PRESCALE_BITS-1:0] pre_q;
    logic [PRESCALE_BITS-1:0] pre_d;
    logic [PRESCALE_BITS-1:0] pre_base;
    logic [WD_BITS-1:0] wd_q;
    logic [WD_BITS-1:0] wd_d;
    logic timeout_q;
    logic wd_tick;
    logic wd_over;

    // Service keeps only the stages below the cleared span
    assign pre_base = service ? (pre_q & KEEP_MASK) : pre_q;
    // Terminal count of 12 stages: at least 4080 ticks after a service
    assign wd_tick = osc_tick && !service && (pre_q == '1);
    assign pre_d = osc_tick ? pre_base + PRE_ONE : pre_base;
    assign wd_over = wd_tick && (wd_q == '1);
    assign wd_d = service ? '0 : (wd_tick ? wd_q + WD_ONE : wd_q);

    // Counters run only while not held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_q <= '0;
            wd_q <= '0;
            timeout_q <= 1'b0;
        end else if (hold) begin
            pre_q <= '0;
            wd_q <= '0;
            timeout_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            wd_q <= wd_d;
            timeout_q <= wd_over;
        end
    end

    assign timeout = timeout_q;

endmodule

/* src/sysrv_top.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Watchdog overflow resets, sets watchdog cause
// - Internal resets drive reset pin low
// - Service write clears watchdog, prescale stages
// - Prescale tick at least every 4080
// - Test voltage in monitor disables watchdog
// - Break state with test voltage on reset pin disables
// - Illegal instruction resets, sets opcode cause
// - Stop without allow is illegal opcode
// - Opcode fetch unmapped resets, sets address cause
// - Data fetch unmapped never resets
// - Undervoltage resets, sets undervoltage cause
// - Stack pointer preset to 00ff
// - Program counter loaded from reset vector
// - Service location reads vector low byte
// - Three read-only pending flag bytes
// - Fixed vectors, priority rising with address
module sysrv_top
    import sysrv_pkg::*;
#(
    parameter int WD_BITS = 8
) (
    input wire logic clk, // System clock, 20 MHz
    input wire logic reset, // Async reset, active high
    input wire logic [15:0] bus_addr, // Register address
    input wire logic [7:0] bus_wdata, // Register write data
    input wire logic bus_we, // Write strobe
    input wire logic bus_re, // Read strobe
    output logic [7:0] bus_rdata, // Read data, cycle after strobe
    input wire logic osc_clk_in, // Internal oscillator clock
    input wire logic uv_detect_in, // Undervoltage detector output
    input wire logic hv_rst_in, // Test high voltage on reset pin
    input wire logic hv_irq_in, // Test high voltage on irq pin
    input wire logic monitor_mode, // Core in monitor mode
    input wire logic break_state, // Core in break state
    input wire logic core_fetch, // Core fetch strobe
    input wire logic core_fetch_opcode, // Fetch is an opcode fetch
    input wire logic core_fetch_unmapped, // Fetch address is unmapped
    input wire logic core_bad_opcode, // Decoded illegal instruction
    input wire logic core_stop_exec, // Stop instruction executed
    input wire logic stop_allow, // Option bit allowing stop
    input wire logic [15:1] irq_src, // Pending interrupt lines
    input wire logic rst_pin_in, // Reset pin level
    output logic rst_pin_out, // Reset pin drive value
    output logic rst_pin_oe, // Reset pin drive enable
    output logic sys_reset, // Chip reset, high while sequencing
    output logic core_sp_load, // Stack pointer preset strobe
    output logic [15:0] core_sp_value, // Stack pointer preset value
    output logic vec_re, // Vector read strobe
    output logic [15:0] vec_addr, // Vector read address
    input wire logic [7:0] vec_rdata, // Vector data, cycle after
    output logic core_pc_load, // Program counter load pulse
    output logic [15:0] core_pc_value, // Program counter value
    output logic [15:0] irq_vector, // Vector of top pending flag
    output logic irq_any, // Some flag pending
    output logic irq_out // Masked event interrupt
);

    localparam logic [RST_CNT_W-1:0] HOLD_LOAD = RST_CNT_W'(RST_HOLD_CYCLES - 1);
    localparam logic [RST_CNT_W-1:0] CNT_ONE = RST_CNT_W'(1);

    generate
        if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES > (1 << RST_CNT_W)) begin : g_bad_hold
            $error("sysrv_top: reset hold count does not fit its counter");
        end
    endgenerate

    // Synchronised pin levels
    logic [4:0] sync_out;
    logic osc_s;
    logic uv_s;
    logic hv_rst_s;
    logic hv_irq_s;
    logic pin_s;

    sysrv_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din({osc_clk_in, uv_detect_in, hv_rst_in, hv_irq_in, rst_pin_in}),
        .dout(sync_out)
    );

    assign osc_s = sync_out[4];
    assign uv_s = sync_out[3];
    assign hv_rst_s = sync_out[2];
    assign hv_irq_s = sync_out[1];
    assign pin_s = sync_out[0];

    // Registers
    sysrv_state_t state_q;
    sysrv_state_t state_d;
    logic [RST_CNT_W-1:0] hold_cnt_q;
    logic [RST_CNT_W-1:0] hold_cnt_d;
    logic drive_q;
    logic drive_d;
    logic osc_prev_q;
    logic [7:0] cause_q;
    logic [7:0] cause_d;
    logic [7:0] istat_q;
    logic [7:0] istat_d;
    logic [7:0] imask_q;
    logic [15:1] pend_q;
    logic [7:0] vec_hi_q;
    logic [7:0] vec_lo_q;
    logic [15:0] pc_q;
    logic pc_load_q;
    logic [15:0] irq_vec_q;
    logic irq_any_q;
    logic [7:0] rdata_q;

    // Oscillator edge; rising edges only, sampled at the fast system clock
    logic osc_tick;
    assign osc_tick = osc_s && !osc_prev_q;

    // Watchdog gating is pure logic on the live test-voltage levels, so a
    // noise pulse cannot latch the watchdog off
    logic wd_disable;
    logic wd_hold;
    logic wd_service;
    logic wd_timeout;
    assign wd_disable = (monitor_mode && (hv_rst_s || hv_irq_s))
                        || (break_state && hv_rst_s);
    assign wd_hold = sys_reset || wd_disable;
    assign wd_service = bus_we && (bus_addr == ADDR_WDOG_SVC);

    sysrv_wdog #(
        .WD_BITS(WD_BITS)
    ) u_wdog (
        .clk(clk),
        .reset(reset),
        .hold(wd_hold),
        .osc_tick(osc_tick),
        .service(wd_service),
        .timeout(wd_timeout)
    );

    // Reset sources; core-side sources count only while the core runs
    logic running;
    logic trig_wdog;
    logic trig_badop;
    logic trig_badadr;
    logic trig_uv;
    logic trig_pin;
    logic trig_int;
    logic trig_any;
    logic [7:0] trig_vec;

    assign running = (state_q == ST_RUN);
    assign trig_wdog = wd_timeout;
    assign trig_badop = running && (core_bad_opcode
                        || (core_stop_exec && !stop_allow));
    // The opcode qualifier keeps data fetches harmless
    assign trig_badadr = running && core_fetch && core_fetch_opcode
                         && core_fetch_unmapped;
    assign trig_uv = uv_s;
    assign trig_pin = running && !pin_s;
    assign trig_int = trig_wdog || trig_badop || trig_badadr || trig_uv;
    assign trig_any = trig_int || trig_pin;

    // One bit per source that fired in this cycle
    always_comb begin
        trig_vec = 8'h00;
        trig_vec[CAUSE_WDOG] = trig_wdog;
        trig_vec[CAUSE_BADOP] = trig_badop;
        trig_vec[CAUSE_BADADR] = trig_badadr;
        trig_vec[CAUSE_UV] = trig_uv;
        trig_vec[CAUSE_PIN] = trig_pin;
    end

    // Cause holds only the sources of the latest reset; a level held
    // undervoltage keeps rewriting the same bit
    assign cause_d = trig_any ? trig_vec : cause_q;

    // Sequencer next state; any trigger restarts the hold phase
    always_comb begin
        state_d = state_q;
        hold_cnt_d = hold_cnt_q;
        drive_d = drive_q;
        if (trig_any) begin
            state_d = ST_HOLD;
            hold_cnt_d = HOLD_LOAD;
            drive_d = drive_q || trig_int;
        end else begin
            case (state_q)
                ST_RUN: begin
                    state_d = ST_RUN;
                end
                ST_HOLD: begin
                    if (hold_cnt_q == '0) begin
                        state_d = ST_WAIT_PIN;
                        drive_d = 1'b0;
                    end else begin
                        hold_cnt_d = hold_cnt_q - CNT_ONE;
                    end
                end
                ST_WAIT_PIN: begin
                    // Wait for the pin to rise so our own drive is never
                    // mistaken for an external reset
                    if (pin_s) begin
                        state_d = ST_VEC_HI;
                    end
                end
                ST_VEC_HI: begin
                    state_d = ST_VEC_LO;
                end
                ST_VEC_LO: begin
                    state_d = ST_LOAD;
                end
                ST_LOAD: begin
                    state_d = ST_RUN;
                end
                default: begin
                    state_d = ST_HOLD;
                    hold_cnt_d = HOLD_LOAD;
                    drive_d = 1'b1;
                end
            endcase
        end
    end

    // Sequencer registers; power-up starts in the hold phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_HOLD;
            hold_cnt_q <= HOLD_LOAD;
            drive_q <= 1'b1;
            osc_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
            drive_q <= drive_d;
            osc_prev_q <= osc_s;
        end
    end

    // Open-drain reset pin: drive low or float
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = drive_q;
    assign sys_reset = !running;

    // Stack pointer preset stands for the whole reset
    assign core_sp_load = sys_reset;
    assign core_sp_value = SP_RESET;

    // Vector fetch: high byte first, data one cycle after each strobe
    assign vec_re = (state_q == ST_VEC_HI) || (state_q == ST_VEC_LO);
    assign vec_addr = (state_q == ST_VEC_LO) ? VEC_RESET_LO : VEC_RESET_HI;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vec_hi_q <= 8'h00;
            vec_lo_q <= 8'h00;
            pc_q <= 16'h0000;
            pc_load_q <= 1'b0;
        end else begin
            if (state_q == ST_VEC_LO) begin
                vec_hi_q <= vec_rdata;
            end
            if (state_q == ST_LOAD) begin
                vec_lo_q <= vec_rdata;
                pc_q <= {vec_hi_q, vec_rdata};
            end
            pc_load_q <= (state_q == ST_LOAD) && !trig_any;
        end
    end

    assign core_pc_load = pc_load_q;
    assign core_pc_value = pc_q;

    // Pending flags mirror the sources and are cleared through any reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= '0;
        end else if (sys_reset) begin
            pend_q <= '0;
        end else begin
            pend_q <= irq_src;
        end
    end

    // Lowest flag number sits at the highest vector and wins
    function automatic logic [15:0] top_vector(input logic [15:1] flags);
        logic [15:0] v;
        v = 16'h0000;
        for (int n = 15; n >= 1; n--) begin
            if (flags[n]) begin
                v = VEC_IRQ_BASE - 16'(2 * n);
            end
        end
        return v;
    endfunction

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_vec_q <= 16'h0000;
            irq_any_q <= 1'b0;
        end else begin
            irq_vec_q <= top_vector(pend_q);
            irq_any_q <= |pend_q;
        end
    end

    assign irq_vector = irq_vec_q;
    assign irq_any = irq_any_q;

    // Pending bytes; unused flag positions read as zero
    logic [7:0] pend_a;
    logic [7:0] pend_b;
    logic [7:0] pend_c;
    assign pend_a = {pend_q[6], pend_q[5], pend_q[4], pend_q[3], 1'b0, pend_q[1], 2'b00};
    assign pend_b = {pend_q[14], pend_q[13], pend_q[12], pend_q[11], 2'b00,
                     pend_q[8], pend_q[7]};
    assign pend_c = {7'h00, pend_q[15]};

    // Register decode; writes to read-only bytes are dropped
    logic sel_cause;
    logic sel_istat;
    logic sel_imask;
    logic sel_pa;
    logic sel_pb;
    logic sel_pc;
    logic sel_svc;
    logic istat_rd;
    logic imask_wr;
    logic [7:0] rdata_d;

    assign sel_cause = (bus_addr == ADDR_CAUSE);
    assign sel_istat = (bus_addr == ADDR_ISTAT);
    assign sel_imask = (bus_addr == ADDR_IMASK);
    assign sel_pa = (bus_addr == ADDR_PEND_A);
    assign sel_pb = (bus_addr == ADDR_PEND_B);
    assign sel_pc = (bus_addr == ADDR_PEND_C);
    assign sel_svc = (bus_addr == ADDR_WDOG_SVC);
    assign istat_rd = bus_re && sel_istat;
    assign imask_wr = bus_we && sel_imask;

    // Read mux; unmapped addresses answer zero
    assign rdata_d = sel_cause ? cause_q :
                     sel_istat ? istat_q :
                     sel_imask ? imask_q :
                     sel_pa ? pend_a :
                     sel_pb ? pend_b :
                     sel_pc ? pend_c :
                     sel_svc ? vec_lo_q :
                     8'h00;

    // Read clears status, but an event in the same cycle is kept
    assign istat_d = (istat_q & ~{8{istat_rd}}) | trig_vec;

    // Cause survives the internal reset it reports; only the
    // hard reset clears status and mask
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cause_q <= CAUSE_RESET;
            istat_q <= ISTAT_RESET;
            imask_q <= IMASK_RESET;
            rdata_q <= 8'h00;
        end else begin
            cause_q <= cause_d;
            istat_q <= istat_d;
            if (imask_wr) begin
                imask_q <= bus_wdata;
            end
            rdata_q <= bus_re ? rdata_d : 8'h00;
        end
    end

    assign bus_rdata = rdata_q;
    assign irq_out = |(istat_q & imask_q);

endmodule

/* dv/sysrv_core_model.sv */
`timescale 1ns/100ps
module sysrv_core_model #(
    parameter logic [7:0] VHI = 8'h12, // Reset vector high byte
    parameter logic [7:0] VLO = 8'h34 // Reset vector low byte
) (
    input wire logic clk, // System clock
    input wire logic vec_re, // Vector read strobe
    input wire logic [15:0] vec_addr, // Vector address
    output logic [7:0] vec_rdata // Vector data, cycle after strobe
);
    logic [7:0] dq = 8'h5a;
    assign vec_rdata = dq;
    // Answer one cycle after the strobe; otherwise the bus churns so stale data never looks valid
    always @(posedge clk) begin
        if (vec_re && vec_addr == 16'hfffe) begin
            dq <= VHI;
        end else if (vec_re && vec_addr == 16'hffff) begin
            dq <= VLO;
        end else begin
            dq <= ~dq;
        end
    end
endmodule

/* dv/sysrv_top_asserts.sv */
`timescale 1ns/100ps
module sysrv_top_asserts
    import sysrv_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic uv_detect_in, // Undervoltage
    input wire logic core_fetch, // Fetch strobe
    input wire logic core_fetch_opcode, // Opcode fetch
    input wire logic core_fetch_unmapped, // Unmapped fetch
    input wire logic core_bad_opcode, // Illegal instruction
    input wire logic core_stop_exec, // Stop executed
    input wire logic stop_allow, // Stop allowed
    input wire logic rst_pin_out, // Pin drive value
    input wire logic rst_pin_oe, // Pin drive enable
    input wire logic sys_reset, // Chip reset
    input wire logic core_sp_load, // Stack preset strobe
    input wire logic [15:0] core_sp_value, // Stack preset value
    input wire logic vec_re, // Vector strobe
    input wire logic [15:0] vec_addr, // Vector address
    input wire logic [7:0] vec_rdata, // Vector data
    input wire logic core_pc_load, // Counter load
    input wire logic [15:0] core_pc_value // Counter value
);
    // Core strobes count only while running, so every core-strobe antecedent excludes reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    a_badop_resets: assert property (
        (core_bad_opcode && !sys_reset) |-> ##[1:2] (sys_reset && rst_pin_oe))
        else $error("illegal instruction did not reset");
    a_stop_illegal: assert property (
        (core_stop_exec && !stop_allow && !sys_reset) |-> ##[1:2] rst_pin_oe)
        else $error("disallowed stop did not reset");
    a_badaddr_resets: assert property (
        (core_fetch && core_fetch_opcode && core_fetch_unmapped && !sys_reset)
        |-> ##[1:2] rst_pin_oe)
        else $error("unmapped opcode fetch did not reset");
    a_uv_resets: assert property (
        $rose(uv_detect_in) |-> ##[1:5] sys_reset)
        else $error("undervoltage did not reset");
    a_pin_pull_low: assert property (
        rst_pin_oe |-> (!rst_pin_out && sys_reset))
        else $error("reset pin driven outside reset or high");
    a_sp_preset: assert property (
        sys_reset |-> (core_sp_load && core_sp_value == 16'h00ff))
        else $error("stack preset missing during reset");
    a_vec_order: assert property (
        $rose(vec_re) |-> (vec_addr == 16'hfffe) ##1 (vec_re && vec_addr == 16'hffff))
        else $error("vector fetch order wrong");
    a_pc_vector: assert property (
        core_pc_load |-> core_pc_value == {$past(vec_rdata, 2), $past(vec_rdata)})
        else $error("program counter not the fetched vector");
    a_exit_loads_pc: assert property (
        $fell(sys_reset) |-> core_pc_load ##1 !core_pc_load)
        else $error("leaving reset without one counter load");
endmodule

bind sysrv_top sysrv_top_asserts i_sysrv_top_asserts (.clk, .reset, .uv_detect_in,
    .core_fetch, .core_fetch_opcode, .core_fetch_unmapped, .core_bad_opcode,
    .core_stop_exec, .stop_allow, .rst_pin_out, .rst_pin_oe, .sys_reset, .core_sp_load,
    .core_sp_value, .vec_re, .vec_addr, .vec_rdata, .core_pc_load, .core_pc_value);

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import sysrv_pkg::*;
    localparam logic [7:0] VHI = 8'ha5;
    localparam logic [7:0] VLO = 8'h3c;
    localparam logic [7:0] CAUSE_K [4] = '{8'h10, 8'h10, 8'h08, 8'h02};
    logic clk = 1'b0, reset = 1'b1, osc_clk_in = 1'b0, bus_we = 1'b0, bus_re = 1'b0;
    logic uv_detect_in = 1'b0, hv_rst_in = 1'b0, hv_irq_in = 1'b0, stop_allow = 1'b1;
    logic monitor_mode = 1'b0, break_state = 1'b0, core_fetch = 1'b0;
    logic core_fetch_opcode = 1'b0, core_fetch_unmapped = 1'b0;
    logic core_bad_opcode = 1'b0, core_stop_exec = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic [15:1] irq_src = 15'h0000;
    logic rst_pin_in, rst_pin_out, rst_pin_oe, sys_reset, core_sp_load, vec_re;
    logic core_pc_load, irq_any, irq_out;
    logic [7:0] bus_rdata, vec_rdata;
    logic [15:0] core_sp_value, vec_addr, core_pc_value, irq_vector;
    int error_cnt = 0, cmp_count = 0, cyc = 0, rst_cyc = 0, seed = 32'h0099;

    // Reset pin has a pull-up; one watchdog bit keeps the timeout within the run
    assign rst_pin_in = rst_pin_oe ? rst_pin_out : 1'b1;
    sysrv_top #(.WD_BITS(1)) i_sysrv_top (.clk, .reset, .bus_addr, .bus_wdata, .bus_we,
        .bus_re, .bus_rdata, .osc_clk_in, .uv_detect_in, .hv_rst_in, .hv_irq_in,
        .monitor_mode, .break_state, .core_fetch, .core_fetch_opcode, .core_fetch_unmapped,
        .core_bad_opcode, .core_stop_exec, .stop_allow, .irq_src, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe, .sys_reset, .core_sp_load, .core_sp_value, .vec_re,
        .vec_addr, .vec_rdata, .core_pc_load, .core_pc_value, .irq_vector, .irq_any,
        .irq_out);
    sysrv_core_model #(.VHI(VHI), .VLO(VLO)) i_sysrv_core_model (.clk, .vec_re,
        .vec_addr, .vec_rdata);

    // Oscillator slower than clk so its two-stage sync sees every edge
    always #25 clk = ~clk;
    always #55 osc_clk_in = ~osc_clk_in;

    // Hang guard and a tally of cycles spent in reset
    always @(posedge clk) begin
        cyc++;
        rst_cyc += (sys_reset === 1'b1);
        if (cyc == 90000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_we <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_we <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_re <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_re <= 1'b0;
        #1;
        chk(bus_rdata, e);
    endtask

    // Wait for the counter load that ends a reset; note whether the pin was pulled
    task automatic boot(output bit oe);
        oe = 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            #1;
            oe |= (rst_pin_oe === 1'b1);
            if (core_pc_load === 1'b1) break;
        end
        chk(core_pc_load, 1'b1);
        chk(core_pc_value, {VHI, VLO});
    endtask

    // Kinds: 0 bad opcode, 1 stop disallowed, 2 unmapped opcode, 3 undervoltage,
    // 4 stop allowed, 5 unmapped data fetch
    task automatic trig(input int k);
        @(posedge clk);
        stop_allow <= (k != 1);
        core_bad_opcode <= (k == 0);
        core_stop_exec <= (k == 1 || k == 4);
        core_fetch <= (k == 2 || k == 5);
        core_fetch_opcode <= (k == 2);
        core_fetch_unmapped <= (k == 2 || k == 5);
        uv_detect_in <= (k == 3);
        @(posedge clk);
        {core_bad_opcode, core_stop_exec, core_fetch, core_fetch_opcode} <= 4'h0;
        core_fetch_unmapped <= 1'b0;
        repeat (3) @(posedge clk);
        uv_detect_in <= 1'b0;
        stop_allow <= 1'b1;
    endtask

    function automatic logic [23:0] pend_exp(input logic [15:1] s);
        return {7'h00, s[15], s[14:11], 2'b00, s[8:7], s[6:3], 1'b0, s[1], 2'b00};
    endfunction

    function automatic logic [15:0] vec_exp(input logic [15:1] s);
        for (int n = 1; n <= 15; n++) begin
            if (s[n]) return VEC_IRQ_BASE - 16'(2 * n);
        end
        return 16'h0000;
    endfunction

    initial begin
        logic [15:1] s;
        logic [23:0] p;
        bit oe;
        int n;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        boot(oe);
        rdc(ADDR_CAUSE, CAUSE_RESET);
        rdc(ADDR_WDOG_SVC, VLO);
        rdc(16'h1234, 8'h00);
        $display("boot test done");
        // Flag 14 and flag 15 first, then random sets of the implemented flags
        for (int i = 0; i < 10; i++) begin
            s = (i == 0) ? 15'h2000 : (i == 1) ? 15'h4000 : 15'($random(seed));
            s[2] = 1'b0;
            s[9] = 1'b0;
            s[10] = 1'b0;
            p = pend_exp(s);
            @(posedge clk);
            irq_src <= s;
            repeat (3) @(posedge clk);
            #1;
            chk(irq_vector, vec_exp(s));
            chk(irq_any, |s);
            wr(ADDR_PEND_A + 16'(i % 3), 8'($random(seed)));
            for (int r = 0; r < 3; r++) begin
                rdc(ADDR_PEND_A + 16'(r), p[8*r +: 8]);
            end
        end
        @(posedge clk) irq_src <= 15'h0000;
        $display("pending flag test done");
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_WDOG_SVC, 8'($random(seed)));
            wr(ADDR_IMASK, (k == 0) ? 8'h00 : 8'hff);
            rdc(ADDR_IMASK, (k == 0) ? 8'h00 : 8'hff);
            n = rst_cyc;
            trig(k);
            if (k >= 4) begin
                repeat (4) @(posedge clk);
                chk(rst_cyc - n, 0);
            end else begin
                boot(oe);
                chk(oe, 1'b1);
                rdc(ADDR_CAUSE, CAUSE_K[k]);
                chk(irq_out, k != 0);
                rdc(ADDR_ISTAT, CAUSE_K[k]);
                chk(irq_out, 1'b0);
                rdc(ADDR_ISTAT, 8'h00);
            end
        end
        $display("reset source test done");
        n = rst_cyc;
        for (int w = 0; w < 2; w++) begin
            @(posedge clk);
            {monitor_mode, hv_irq_in, break_state, hv_rst_in} <= w ? 4'h3 : 4'hc;
            repeat (20000) @(posedge clk);
            chk(rst_cyc - n, 0);
        end
        {monitor_mode, hv_irq_in, break_state, hv_rst_in} <= 4'h0;
        repeat (6) begin
            wr(ADDR_WDOG_SVC, 8'($random(seed)));
            repeat (4000) @(posedge clk);
        end
        chk(rst_cyc - n, 0);
        for (int i = 0; i < 20000 && sys_reset !== 1'b1; i++) @(posedge clk);
        boot(oe);
        chk(oe, 1'b1);
        rdc(ADDR_CAUSE, 8'h20);
        $display("watchdog test done");
        give_verdict();
    end
endmodule
